// ---- rtl/mmwc_pkg.sv ----
// Behaviour
// - Function 0F drives each addressed reset or clear coil from its packed data bit; addressed flag coils are left alone.
// - Coil bits are packed LSB first; unused bits of the last byte are zero.
// - After 0F the reply is station, function, start and quantity, no data.
// - Function 10 writes 16-bit values into consecutive holding registers from start.
// - After 10 the reply is station, function, start and quantity only.
// - Readable, writable reset coils per channel and average clear historical max or min.
// - Eight write-only coils each clear one logic engine counter.
// - Burnout flag is one while the channel detects no sensor, else zero.
// - High alarm is one above high limit; low alarm is one below low limit.
package mmwc_pkg;
	localparam logic [7:0] FC_FORCE = 8'h0F;
	localparam logic [7:0] FC_PRESET = 8'h10;
	localparam logic [7:0] STATION_RST = 8'h01;
	localparam logic [15:0] COIL_RMAX = 16'h0065;
	localparam logic [15:0] COIL_RMIN = 16'h006F;
	localparam logic [15:0] COIL_BURN = 16'h0079;
	localparam logic [15:0] COIL_HI = 16'h0083;
	localparam logic [15:0] COIL_LO = 16'h008D;
	localparam logic [15:0] COIL_CLR = 16'h012D;
	localparam logic [3:0] HDR_LEN = 4'h7;
	localparam logic [2:0] RESP_LEN = 3'h6;
	localparam logic [11:0] OFS_STATION = 12'h000;
	localparam logic [11:0] OFS_COILS = 12'h004;
	localparam logic [11:0] OFS_FLAGS = 12'h008;
	localparam logic [11:0] OFS_FRAMES = 12'h00C;

	typedef enum logic [1:0] {ST_RX, ST_DROP, ST_RESP} mmwc_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mmwc_apb_req_t;

	typedef struct packed {
		mmwc_state_t st;
		logic [3:0] idx;
		logic [7:0] station;
		logic [7:0] func;
		logic [15:0] start;
		logic [15:0] qty;
		logic [15:0] done;
		logic [7:0] hibyte;
		logic odd;
		logic [8:0] rmax;
		logic [8:0] rmin;
		logic [7:0] clr;
		logic [6:0] burn;
		logic [8:0] hi;
		logic [8:0] lo;
		logic hwe;
		logic [15:0] haddr;
		logic [15:0] hdata;
		logic rx_ready;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_last;
		logic [2:0] txi;
		logic [15:0] frames;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} mmwc_state_s_t;
endpackage : mmwc_pkg

// ---- rtl/mmwc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module mmwc_top (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// APB slave
	input wire mmwc_pkg::mmwc_apb_req_t APB_REQ,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Request byte stream
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_LAST,
	output logic RX_READY,
	// Response byte stream
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	output logic TX_LAST,
	input wire logic TX_READY,
	// Holding register writes
	output logic HREG_WE,
	output logic [15:0] HREG_ADDR,
	output logic [15:0] HREG_DATA,
	// Channel status in
	input wire logic [6:0] SENSOR_OK,
	input wire logic [143:0] AI_VALUE,
	input wire logic [143:0] HI_LIMIT,
	input wire logic [143:0] LO_LIMIT,
	// Coil outputs
	output logic [8:0] RST_MAX,
	output logic [8:0] RST_MIN,
	output logic [7:0] CNT_CLR,
	output logic [6:0] BURNOUT,
	output logic [8:0] HI_ALARM,
	output logic [8:0] LO_ALARM
);
	mmwc_pkg::mmwc_state_s_t s_q, s_d;

	function automatic logic in_run(input logic [15:0] a, input logic [15:0] base,
		input logic [3:0] n);
		in_run = (a >= base) && (a < base + {12'h000, n});
	endfunction : in_run

	function automatic logic [7:0] resp_byte(input mmwc_pkg::mmwc_state_s_t s);
		case (s.txi)
			3'h0: resp_byte = s.station;
			3'h1: resp_byte = s.func;
			3'h2: resp_byte = s.start[15:8];
			3'h3: resp_byte = s.start[7:0];
			3'h4: resp_byte = s.qty[15:8];
			default: resp_byte = s.qty[7:0];
		endcase
	endfunction : resp_byte

	wire logic rx_take = RX_VALID && s_q.rx_ready;
	wire logic apb_acc = APB_REQ.psel && APB_REQ.penable;

	always_comb begin
		logic [15:0] n;
		logic [15:0] a;
		logic [3:0] k;
		n = 16'h0000;
		a = 16'h0000;
		k = 4'h0;
		s_d = s_q;
		s_d.clr = 8'h00;
		s_d.hwe = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		// Flags follow the inputs; no client path reaches them.
		s_d.burn = ~SENSOR_OK;
		for (int c = 0; c < 9; c++) begin
			s_d.hi[c] = AI_VALUE[c*16 +: 16] > HI_LIMIT[c*16 +: 16];
			s_d.lo[c] = AI_VALUE[c*16 +: 16] < LO_LIMIT[c*16 +: 16];
		end
		case (s_q.st)
			mmwc_pkg::ST_RX: begin
				if (rx_take) begin
					if (s_q.idx < mmwc_pkg::HDR_LEN)
						s_d.idx = s_q.idx + 4'h1;
					case (s_q.idx)
						4'h0: if (RX_DATA != s_q.station) s_d.st = mmwc_pkg::ST_DROP;
						4'h1: begin
							s_d.func = RX_DATA;
							if (RX_DATA != mmwc_pkg::FC_FORCE && RX_DATA != mmwc_pkg::FC_PRESET)
								s_d.st = mmwc_pkg::ST_DROP;
						end
						4'h2: s_d.start[15:8] = RX_DATA;
						4'h3: s_d.start[7:0] = RX_DATA;
						4'h4: s_d.qty[15:8] = RX_DATA;
						4'h5: s_d.qty[7:0] = RX_DATA;
						4'h6: begin
							s_d.done = 16'h0000;
							s_d.odd = 1'b0;
						end
						default: begin
							if (s_q.func == mmwc_pkg::FC_FORCE) begin
								// Bits past the quantity are padding and touch nothing.
								for (int b = 0; b < 8; b++) begin
									n = s_q.done + 16'(b);
									a = s_q.start + n;
									if (n < s_q.qty) begin
										if (in_run(a, mmwc_pkg::COIL_RMAX, 4'h9)) begin
											k = 4'(a - mmwc_pkg::COIL_RMAX);
											s_d.rmax[k] = RX_DATA[b];
										end else if (in_run(a, mmwc_pkg::COIL_RMIN, 4'h9)) begin
											k = 4'(a - mmwc_pkg::COIL_RMIN);
											s_d.rmin[k] = RX_DATA[b];
										end else if (in_run(a, mmwc_pkg::COIL_CLR, 4'h8)) begin
											k = 4'(a - mmwc_pkg::COIL_CLR);
											s_d.clr[k[2:0]] = RX_DATA[b];
										end
									end
								end
								s_d.done = s_q.done + 16'h0008;
							end else begin
								s_d.odd = ~s_q.odd;
								if (!s_q.odd) begin
									s_d.hibyte = RX_DATA;
								end else if (s_q.done < s_q.qty) begin
									s_d.hwe = 1'b1;
									s_d.haddr = s_q.start + s_q.done;
									s_d.hdata = {s_q.hibyte, RX_DATA};
									s_d.done = s_q.done + 16'h0001;
								end
							end
						end
					endcase
					if (RX_LAST) begin
						s_d.idx = 4'h0;
						if (s_d.st == mmwc_pkg::ST_RX && s_q.idx >= 4'h6) begin
							s_d.st = mmwc_pkg::ST_RESP;
							s_d.rx_ready = 1'b0;
							s_d.txi = 3'h0;
						end else begin
							s_d.st = mmwc_pkg::ST_RX;
						end
					end
				end
			end
			mmwc_pkg::ST_DROP: begin
				if (rx_take && RX_LAST) begin
					s_d.st = mmwc_pkg::ST_RX;
					s_d.idx = 4'h0;
				end
			end
			default: begin
				// Echo header only; data bytes are never returned.
				if (!s_q.tx_valid || TX_READY) begin
					if (s_q.txi == mmwc_pkg::RESP_LEN) begin
						s_d.tx_valid = 1'b0;
						s_d.tx_last = 1'b0;
						s_d.st = mmwc_pkg::ST_RX;
						s_d.rx_ready = 1'b1;
						s_d.frames = s_q.frames + 16'h0001;
					end else begin
						s_d.tx_valid = 1'b1;
						s_d.tx_data = resp_byte(s_q);
						s_d.tx_last = s_q.txi == mmwc_pkg::RESP_LEN - 3'h1;
						s_d.txi = s_q.txi + 3'h1;
					end
				end
			end
		endcase
		// APB answers one cycle into the access phase.
		if (apb_acc && !s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			if (APB_REQ.paddr == mmwc_pkg::OFS_STATION) begin
				s_d.prdata = {24'h00_0000, s_q.station};
				if (APB_REQ.pwrite)
					s_d.station = APB_REQ.pwdata[7:0];
			end else if (APB_REQ.paddr == mmwc_pkg::OFS_COILS) begin
				s_d.prdata = {14'h0000, s_q.rmin, s_q.rmax};
			end else if (APB_REQ.paddr == mmwc_pkg::OFS_FLAGS) begin
				s_d.prdata = {7'h00, s_q.lo, s_q.hi, s_q.burn};
			end else if (APB_REQ.paddr == mmwc_pkg::OFS_FRAMES) begin
				s_d.prdata = {16'h0000, s_q.frames};
			end else begin
				s_d.pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			s_q <= '0;
			s_q.station <= mmwc_pkg::STATION_RST;
			s_q.rx_ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign RX_READY = s_q.rx_ready;
	assign TX_VALID = s_q.tx_valid;
	assign TX_DATA = s_q.tx_data;
	assign TX_LAST = s_q.tx_last;
	assign HREG_WE = s_q.hwe;
	assign HREG_ADDR = s_q.haddr;
	assign HREG_DATA = s_q.hdata;
	assign RST_MAX = s_q.rmax;
	assign RST_MIN = s_q.rmin;
	assign CNT_CLR = s_q.clr;
	assign BURNOUT = s_q.burn;
	assign HI_ALARM = s_q.hi;
	assign LO_ALARM = s_q.lo;

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	clr_needs_force_a: assert property (
		CNT_CLR != 8'h00 |-> s_q.func == mmwc_pkg::FC_FORCE)
		else $error("Counter clear outside a coil force.");
	hreg_needs_preset_a: assert property (HREG_WE |-> s_q.func == mmwc_pkg::FC_PRESET)
		else $error("Holding write outside a preset.");
	hreg_addr_run_a: assert property (
		HREG_WE |-> HREG_ADDR == s_q.start + s_q.done - 16'h0001)
		else $error("Holding write address off the run.");
	resp_station_a: assert property (
		TX_VALID && s_q.txi == 3'h1 |-> TX_DATA == s_q.station)
		else $error("Reply does not open with the station.");
	resp_length_a: assert property (TX_VALID && TX_LAST |-> s_q.txi == mmwc_pkg::RESP_LEN)
		else $error("Reply is not six bytes.");
	// The first edge after reset still shows the cleared flags, so it is skipped.
	burnout_track_a: assert property (
		$past(NRST) |-> BURNOUT == ~$past(SENSOR_OK))
		else $error("Burnout flag does not track the sensor.");
	hi_alarm_a: assert property (
		$past(NRST) |-> HI_ALARM[0] == ($past(AI_VALUE[15:0]) > $past(HI_LIMIT[15:0])))
		else $error("High alarm wrong for channel zero.");
	ro_flags_a: assert property (
		rx_take && s_q.func == mmwc_pkg::FC_FORCE |=>
		LO_ALARM[8] == ($past(AI_VALUE[143:128]) < $past(LO_LIMIT[143:128])))
		else $error("Read-only flag moved by a client write.");
	rmax_hold_a: assert property (s_q.st != mmwc_pkg::ST_RX |=> $stable(RST_MAX))
		else $error("Reset coil changed outside a request.");
endmodule : mmwc_top
`default_nettype wire

// ---- testbench/mmwc_client.sv ----
`timescale 1ns/10ps
`default_nettype none
module mmwc_client (
	// Clock
	input wire logic clk,
	// Request stream
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	input wire logic rx_ready,
	// Reply stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [7:0] rep[$];
	logic slow = 1'b0;
	int n_rep = 0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		tx_ready = 1'b0;
	end
	// Fields go out in frame order, words high byte first, coil bits packed LSB first.
	task send(input logic [7:0] f[$]);
		for (int i = 0; i < f.size(); i++) begin
			rx_valid <= 1'b1;
			rx_data <= f[i];
			rx_last <= (i == f.size() - 1);
			@(posedge clk);
			while (rx_ready !== 1'b1) @(posedge clk);
		end
		// A released data line must not keep showing the last byte.
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_data <= ~f[f.size() - 1];
	endtask : send
	always @(posedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			rep.push_back(tx_data);
			if (tx_last === 1'b1) n_rep <= n_rep + 1;
		end
	end
endmodule : mmwc_client
`default_nettype wire

// ---- testbench/mmwc_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", n, e, a); end end
module mmwc_top_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	mmwc_pkg::mmwc_apb_req_t req = '0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, rxv, rxl, rxr, txv, txl, txr, hwe;
	logic [7:0] rxd, txd, clr, clr_seen = 8'h00;
	logic [15:0] ha, hd;
	logic [8:0] rmax, rmin, hia, loa;
	logic [6:0] burn;
	logic [6:0] sok = 7'h55;
	logic [143:0] aiv = {128'h0, 16'h0100};
	logic [31:0] hq[$];
	int n_fail = 0;
	int n_tests = 0;
	int clr_n = 0;
	initial begin
		forever #25 clk = ~clk;
	end
	mmwc_top DUT (.CLK_SYS(clk), .NRST(nrst), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RX_VALID(rxv), .RX_DATA(rxd), .RX_LAST(rxl), .RX_READY(rxr),
		.TX_VALID(txv), .TX_DATA(txd), .TX_LAST(txl), .TX_READY(txr), .HREG_WE(hwe),
		.HREG_ADDR(ha), .HREG_DATA(hd), .SENSOR_OK(sok), .AI_VALUE(aiv),
		.HI_LIMIT({{8{16'hFFFF}}, 16'h0080}), .LO_LIMIT({16'h0010, 128'h0}), .RST_MAX(rmax),
		.RST_MIN(rmin), .CNT_CLR(clr), .BURNOUT(burn), .HI_ALARM(hia), .LO_ALARM(loa));
	mmwc_client CLI (.clk(clk), .rx_valid(rxv), .rx_data(rxd), .rx_last(rxl), .rx_ready(rxr),
		.tx_valid(txv), .tx_data(txd), .tx_last(txl), .tx_ready(txr));
	// Outputs are unknown until the first reset edge, so they are watched only after reset.
	always @(posedge clk) begin
		if (nrst === 1'b1) begin
			clr_seen <= clr_seen | clr;
			if (clr !== 8'h00) clr_n <= clr_n + 1;
			if (hwe === 1'b1) hq.push_back({ha, hd});
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		req <= '0;
		@(posedge clk);
	endtask : apb
	// Sends one frame and collects the echo, which must be exactly the six header bytes.
	task frame(input logic [7:0] f[$]);
		int k;
		int n0;
		n0 = CLI.n_rep;
		CLI.send(f);
		for (k = 0; k < 300 && CLI.n_rep == n0; k++) @(posedge clk);
		`CHK("reply count", 6, CLI.rep.size())
		for (k = 0; k < 6; k++) `CHK("reply byte", f[k], CLI.rep[k])
		CLI.rep.delete();
	endtask : frame
	task t_force;
		CLI.slow = 1'b1;
		frame('{8'h01, 8'h0F, 8'h00, 8'h65, 8'h00, 8'h09, 8'h02, 8'h45, 8'h01});
		`CHK("rst max", 9'h145, rmax)
		apb(1'b0, 12'h004, 32'h0);
		`CHK("coil word", 32'h00000145, r)
		CLI.slow = 1'b0;
		$display("end force");
	endtask : t_force
	task t_clear;
		frame('{8'h01, 8'h0F, 8'h01, 8'h2D, 8'h00, 8'h08, 8'h01, 8'hA5});
		`CHK("counter clear", 8'hA5, clr_seen)
		`CHK("clear cycles", 1, clr_n)
		$display("end clear");
	endtask : t_clear
	task t_flags;
		frame('{8'h01, 8'h0F, 8'h00, 8'h79, 8'h00, 8'h07, 8'h01, 8'h7F});
		`CHK("burnout", 7'h2A, burn)
		`CHK("high alarm", 9'h001, hia)
		`CHK("low alarm", 9'h100, loa)
		sok <= 7'h2A;
		aiv <= {16'h0020, 112'h0, 16'h0050};
		repeat (2) @(posedge clk);
		`CHK("burnout track", 7'h55, burn)
		`CHK("high alarm off", 9'h000, hia)
		`CHK("low alarm off", 9'h000, loa)
		$display("end flags");
	endtask : t_flags
	task t_drop;
		CLI.send('{8'h07, 8'h0F, 8'h00, 8'h65, 8'h00, 8'h01, 8'h01, 8'h00});
		repeat (20) @(posedge clk);
		`CHK("dropped reply", 0, CLI.rep.size())
		`CHK("rst max kept", 9'h145, rmax)
		$display("end drop");
	endtask : t_drop
	task t_preset;
		frame('{8'h01, 8'h10, 8'h00, 8'h09, 8'h00, 8'h02, 8'h04, 8'h42, 8'hC8, 8'h00, 8'h00});
		`CHK("writes", 2, hq.size())
		`CHK("word 0", 32'h000942C8, hq[0])
		`CHK("word 1", 32'h000A0000, hq[1])
		$display("end preset");
	endtask : t_preset
	task t_apb;
		apb(1'b0, 12'h000, 32'h0);
		`CHK("station", 32'h00000001, r)
		apb(1'b1, 12'h000, 32'h00000002);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("station rw", 32'h00000002, r)
		apb(1'b0, 12'h008, 32'h0);
		`CHK("flag word", 32'h00000055, r)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("frames", 32'h00000004, r)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped err", 1'b1, e)
		$display("end apb");
	endtask : t_apb
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_force;
		t_clear;
		t_flags;
		t_preset;
		t_drop;
		t_apb;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report;
	end
endmodule : mmwc_top_tb
`default_nettype wire
